// File: rtl/pta_table_access.sv
// APB-controlled table read and write path to program memory
//
// Function
// RULE1: Program word address advances by two
// RULE2: Word low read returns bits 15..0
// RULE3: Byte low read picks byte by select
// RULE4: Word high read gives bits 23..16, upper zero
// RULE5: Byte high read of phantom byte is zero
// RULE6: Only high ops reach upper program byte
// RULE7: Page register selects region for every access
// RULE8: Page bit 7 selects configuration space
// RULE9: Writes load buffers only, two cycles
// RULE10: Full address is page above effective address
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module pta_table_access (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [pta_pkg::PTA_WADDR_W-1:0] prog_word_addr,
    output logic prog_cfg_space,
    output logic prog_rd_en,
    input wire logic [pta_pkg::PTA_PROG_W-1:0] prog_rd_data,
    output logic buf_wr_en,
    output logic [pta_pkg::PTA_PROG_W-1:0] buf_wr_data,
    output logic [pta_pkg::PTA_LANE_W-1:0] buf_wr_lane
);
    import pta_pkg::*;

    pta_lane_if lane ();

    pta_lane_fmt u_fmt (
        .lane(lane.fmt)
    );

    function automatic logic is_high(input pta_op_t op);
        return (op == PTA_OP_RD_HIGH) || (op == PTA_OP_WR_HIGH);
    endfunction

    function automatic logic is_write(input pta_op_t op);
        return (op == PTA_OP_WR_LOW) || (op == PTA_OP_WR_HIGH);
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [PTA_PAGE_W-1:0] page;
    logic [PTA_EA_W-1:0] ea;
    logic [PTA_DATA_W-1:0] wdata;
    logic [PTA_DATA_W-1:0] rdata;
    pta_op_t op;
    logic byte_mode;
    logic done;
    pta_state_t state;
    pta_state_t next_state;
    logic [1:0] wr_cnt;
    logic [PTA_PROG_W-1:0] cap_word;
    logic [PTA_PROG_W-1:0] wr_word_q;
    logic [PTA_LANE_W-1:0] wr_lane_q;
    logic [31:0] rd_word;

    // ****************************************
    // Bus decode
    // ****************************************
    wire busy = (state != PTA_ST_IDLE);
    wire wr_xfer = psel && penable && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    wire rd_access = psel && penable && !pwrite;
    wire sel_ctrl = (paddr == PTA_ADDR_CTRL);
    wire sel_page = (paddr == PTA_ADDR_PAGE);
    wire sel_ea = (paddr == PTA_ADDR_EA);
    wire sel_wdata = (paddr == PTA_ADDR_WDATA);
    wire sel_rdata = (paddr == PTA_ADDR_RDATA);
    wire sel_status = (paddr == PTA_ADDR_STATUS);
    wire mapped = sel_ctrl | sel_page | sel_ea | sel_wdata | sel_rdata | sel_status;
    // Setup registers are frozen while an access runs, so the
    // address and data seen by memory stay stable
    wire cfg_we = wr_xfer && !busy;
    wire go = cfg_we && sel_ctrl && pwdata[PTA_CTRL_GO_BIT];
    wire [1:0] go_op = pwdata[PTA_CTRL_OP_LSB +: 2];
    wire [31:0] ctrl_rd = {23'h0, busy, 5'h0, byte_mode, 2'(op)};
    wire [31:0] status_rd = {29'h0, page[PTA_CFG_PAGE_BIT], done, busy};
    wire [31:0] rd_mux =
        sel_ctrl ? ctrl_rd :
        sel_page ? {24'h0, page} :
        sel_ea ? {16'h0, ea} :
        sel_wdata ? {16'h0, wdata} :
        sel_rdata ? {16'h0, rdata} :
        sel_status ? status_rd : 32'h0000_0000;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    // Read word is taken at the setup edge, so the access phase
    // shows a flop and not a mux fed by the bus
    assign prdata = rd_access ? rd_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_word <= 32'h0000_0000;
        end else if (rd_setup) begin
            rd_word <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page <= PTA_PAGE_RST;
        end else if (cfg_we && sel_page) begin
            page <= pwdata[PTA_PAGE_W-1:0]; // [RULE7]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ea <= PTA_EA_RST;
        end else if (cfg_we && sel_ea) begin
            ea <= pwdata[PTA_EA_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdata <= PTA_DATA_RST;
        end else if (cfg_we && sel_wdata) begin
            wdata <= pwdata[PTA_DATA_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op <= PTA_OP_RD_LOW;
            byte_mode <= 1'b0;
        end else if (cfg_we && sel_ctrl) begin
            op <= pta_op_t'(go_op);
            byte_mode <= pwdata[PTA_CTRL_BYTE_BIT];
        end
    end

    // ****************************************
    // Program space addressing
    // ****************************************
    // EA bit 0 is the byte select; each 24-bit word spans two addresses
    assign prog_word_addr = {page, ea[PTA_EA_W-1:1]}; // [RULE1] [RULE10]
    assign prog_cfg_space = page[PTA_CFG_PAGE_BIT]; // [RULE8]

    assign lane.prog_word = cap_word;
    assign lane.wdata = wdata;
    assign lane.high_word = is_high(op);
    assign lane.byte_mode = byte_mode;
    assign lane.byte_sel = ea[0];

    // ****************************************
    // Access sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        unique case (state)
            PTA_ST_IDLE: begin
                if (go) begin
                    next_state = is_write(pta_op_t'(go_op)) ? PTA_ST_WRITE : PTA_ST_RD_REQ;
                end
            end
            PTA_ST_RD_REQ: next_state = PTA_ST_RD_CAP;
            PTA_ST_RD_CAP: next_state = PTA_ST_IDLE;
            PTA_ST_WRITE: begin
                if (wr_cnt == PTA_WR_CLKS - 2'd1) begin
                    next_state = PTA_ST_IDLE;
                end
            end
        endcase
    end

    assign prog_rd_en = (state == PTA_ST_RD_REQ);
    // Writes never start a flash program cycle
    assign buf_wr_en = (state == PTA_ST_WRITE) && (wr_cnt == PTA_WR_CLKS - 2'd1); // [RULE9]
    assign buf_wr_data = wr_word_q;
    assign buf_wr_lane = wr_lane_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PTA_ST_IDLE;
            wr_cnt <= 2'd0;
        end else begin
            state <= next_state;
            wr_cnt <= (state == PTA_ST_WRITE) ? wr_cnt + 2'd1 : 2'd0; // [RULE9]
        end
    end

    // Program word is captured at the edge that ends the fetch strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_word <= '0;
        end else if (prog_rd_en) begin
            cap_word <= prog_rd_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= PTA_DATA_RST;
        end else if (state == PTA_ST_RD_CAP) begin
            rdata <= lane.rd_data; // [RULE2] [RULE4]
        end
    end

    // Steered word is held so the buffer load sees stable data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_word_q <= '0;
            wr_lane_q <= '0;
        end else if (state == PTA_ST_WRITE && wr_cnt == 2'd0) begin
            wr_word_q <= lane.wr_word;
            wr_lane_q <= lane.wr_lane;
        end
    end

    // Only a new start clears done, and no start is taken while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else if (go) begin
            done <= 1'b0;
        end else if (next_state == PTA_ST_IDLE && busy) begin
            done <= 1'b1;
        end
    end
endmodule // pta_table_access

// File: pkg/pta_pkg.sv
// Constants, types and register map of the program space table access block
package pta_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int PTA_PROG_W = 24;
    localparam int PTA_DATA_W = 16;
    localparam int PTA_PAGE_W = 8;
    localparam int PTA_EA_W = 16;
    localparam int PTA_WADDR_W = PTA_PAGE_W + PTA_EA_W - 1;
    localparam int PTA_LANE_W = 3;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [11:0] PTA_ADDR_CTRL = 12'h000;
    localparam logic [11:0] PTA_ADDR_PAGE = 12'h004;
    localparam logic [11:0] PTA_ADDR_EA = 12'h008;
    localparam logic [11:0] PTA_ADDR_WDATA = 12'h00C;
    localparam logic [11:0] PTA_ADDR_RDATA = 12'h010;
    localparam logic [11:0] PTA_ADDR_STATUS = 12'h014;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int PTA_CTRL_OP_LSB = 0;
    localparam int PTA_CTRL_BYTE_BIT = 2;
    localparam int PTA_CTRL_GO_BIT = 8;
    localparam int PTA_STAT_BUSY_BIT = 0;
    localparam int PTA_STAT_DONE_BIT = 1;
    localparam int PTA_STAT_CFG_BIT = 2;
    localparam int PTA_CFG_PAGE_BIT = 7;
    localparam logic [7:0] PTA_PAGE_RST = 8'h00;
    localparam logic [15:0] PTA_EA_RST = 16'h0000;
    localparam logic [15:0] PTA_DATA_RST = 16'h0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int PTA_WR_INSTR_CYCLES = 2;
    localparam int PTA_CLK_PER_INSTR = 1;
    localparam logic [1:0] PTA_WR_CLKS = 2'(PTA_WR_INSTR_CYCLES * PTA_CLK_PER_INSTR);

    typedef enum logic [1:0] {
        PTA_OP_RD_LOW = 2'h0,
        PTA_OP_RD_HIGH = 2'h1,
        PTA_OP_WR_LOW = 2'h2,
        PTA_OP_WR_HIGH = 2'h3
    } pta_op_t;

    typedef enum {
        PTA_ST_IDLE,
        PTA_ST_RD_REQ,
        PTA_ST_RD_CAP,
        PTA_ST_WRITE
    } pta_state_t;
endpackage

// File: pkg/pta_lane_if.sv
// Lane steering signals between the access controller and the formatter
`timescale 1ns/1ps
interface pta_lane_if;
    import pta_pkg::*;
    logic [PTA_PROG_W-1:0] prog_word;
    logic [PTA_DATA_W-1:0] wdata;
    logic high_word;
    logic byte_mode;
    logic byte_sel;
    logic [PTA_DATA_W-1:0] rd_data;
    logic [PTA_PROG_W-1:0] wr_word;
    logic [PTA_LANE_W-1:0] wr_lane;

    modport ctrl (
        output prog_word, wdata, high_word, byte_mode, byte_sel,
        input rd_data, wr_word, wr_lane
    );
    modport fmt (
        input prog_word, wdata, high_word, byte_mode, byte_sel,
        output rd_data, wr_word, wr_lane
    );
endinterface

// File: rtl/pta_lane_fmt.sv
// Byte and word steering between 24-bit program words and 16-bit data
`timescale 1ns/1ps
module pta_lane_fmt (
    pta_lane_if.fmt lane
);
    import pta_pkg::*;

    // ****************************************
    // Read steering
    // ****************************************
    wire [7:0] low_byte_pick = lane.byte_sel ? lane.prog_word[15:8] : lane.prog_word[7:0]; // [RULE3]
    wire [7:0] high_byte = lane.prog_word[23:16];
    // Phantom byte reads zero in byte mode
    wire [7:0] high_byte_pick = lane.byte_sel ? 8'h00 : high_byte; // [RULE5]
    wire [15:0] rd_low = lane.byte_mode ? {8'h00, low_byte_pick} : lane.prog_word[15:0]; // [RULE2]
    wire [15:0] rd_high = lane.byte_mode ? {8'h00, high_byte_pick} : {8'h00, high_byte}; // [RULE4]
    assign lane.rd_data = lane.high_word ? rd_high : rd_low; // [RULE6]

    // ****************************************
    // Write steering into the holding buffer
    // ****************************************
    wire [7:0] wb = lane.wdata[7:0];
    wire [PTA_PROG_W-1:0] wr_low = lane.byte_mode ?
        (lane.byte_sel ? {8'h00, wb, 8'h00} : {16'h0000, wb}) : {8'h00, lane.wdata};
    wire [PTA_LANE_W-1:0] lane_low = lane.byte_mode ?
        (lane.byte_sel ? 3'b010 : 3'b001) : 3'b011;
    // Writing the phantom byte touches nothing
    wire [PTA_LANE_W-1:0] lane_high = (lane.byte_mode && lane.byte_sel) ? 3'b000 : 3'b100;
    assign lane.wr_word = lane.high_word ? {wb, 16'h0000} : wr_low; // [RULE6]
    assign lane.wr_lane = lane.high_word ? lane_high : lane_low;
endmodule // pta_lane_fmt

// File: dv/pta_checker.sv
// Port-level assertions for the table access block
`timescale 1ns/1ps
module pta_checker (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic pready,
    input logic [pta_pkg::PTA_WADDR_W-1:0] prog_word_addr,
    input logic prog_cfg_space,
    input logic prog_rd_en,
    input logic buf_wr_en,
    input logic [pta_pkg::PTA_LANE_W-1:0] buf_wr_lane
);
    import pta_pkg::*;
    logic [1:0] busy_cnt;
    logic high_op;
    // Own busy copy: set-up writes are refused while an op runs
    wire idle_wr = psel && penable && pwrite && pready && busy_cnt == 2'h0;
    wire go = idle_wr && paddr == PTA_ADDR_CTRL && pwdata[PTA_CTRL_GO_BIT];
    wire [7:0] page_in = pwdata[7:0];
    wire [14:0] word_in = pwdata[15:1];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt <= 2'h0;
            high_op <= 1'h0;
        end else if (go) begin
            busy_cnt <= 2'h2;
            high_op <= pwdata[0];
        end else if (busy_cnt != 2'h0) begin
            busy_cnt <= busy_cnt - 2'h1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    rd_fetch_a: assert property (go && !pwdata[1] |=> prog_rd_en)
        else $error("no fetch");
    wr_load_a: assert property (go && pwdata[1] |=> !buf_wr_en ##1 buf_wr_en)
        else $error("no load");
    rd_stray_a: assert property (prog_rd_en |-> busy_cnt == 2'h2 && !buf_wr_en)
        else $error("stray fetch");
    wr_stray_a: assert property (buf_wr_en |-> busy_cnt == 2'h1 && !prog_rd_en)
        else $error("stray load");
    cfg_bit_a: assert property (prog_cfg_space == prog_word_addr[22])
        else $error("bad space");
    page_load_a: assert property (idle_wr && paddr == PTA_ADDR_PAGE
        |=> prog_word_addr[22:15] == $past(page_in)) else $error("bad page");
    word_load_a: assert property (idle_wr && paddr == PTA_ADDR_EA
        |=> prog_word_addr[14:0] == $past(word_in)) else $error("bad word");
    lane_low_a: assert property (buf_wr_en && !high_op |-> !buf_wr_lane[2])
        else $error("low op hit upper byte");
    cover property (go && !pwdata[1]);
    cover property (go && pwdata[1]);
    cover property (prog_rd_en && prog_cfg_space);
    cover property (buf_wr_en && buf_wr_lane == 3'h0);
endmodule // pta_checker

// File: dv/pta_prog_mem.sv
// Program flash stand-in answering fetches of the table access block
`timescale 1ns/1ps
module pta_prog_mem (
    input logic [pta_pkg::PTA_WADDR_W-1:0] prog_word_addr,
    input logic prog_cfg_space,
    input logic prog_rd_en,
    output logic [pta_pkg::PTA_PROG_W-1:0] prog_rd_data
);
    import pta_pkg::*;
    wire [22:0] a = prog_word_addr;
    wire [PTA_PROG_W-1:0] w = {a[7:0] ^ {prog_cfg_space, a[21:15]}, a[15:0] ^ 16'hC396};
    // Inverse outside the fetch cycle, so a late capture cannot pass
    assign prog_rd_data = prog_rd_en ? w : ~w;
endmodule // pta_prog_mem

// File: dv/tb_top.sv
// Self-checking bench for the table access block
`timescale 1ns/1ps
module tb_top;
    import pta_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, q;
    logic pready, pslverr, err, prog_cfg_space, prog_rd_en, buf_wr_en;
    logic [22:0] prog_word_addr, a;
    logic [23:0] prog_rd_data, buf_wr_data, seen_data, w, m, x;
    logic [2:0] buf_wr_lane, seen_lane, el;
    logic [15:0] e, ea;
    logic [7:0] pg;
    int miscompares = 0;
    int n_compared = 0;
    always #5 pclk = ~pclk;
    pta_table_access pta_table_access_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .prog_word_addr, .prog_cfg_space,
        .prog_rd_en, .prog_rd_data, .buf_wr_en, .buf_wr_data, .buf_wr_lane);
    pta_prog_mem pta_prog_mem_inst (.prog_word_addr, .prog_cfg_space, .prog_rd_en,
        .prog_rd_data);
    always @(posedge pclk) begin
        if (buf_wr_en === 1'h1) begin
            seen_lane <= buf_wr_lane;
            seen_data <= buf_wr_data;
        end
    end
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Select stays up so the next call may follow at once
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            miscompares++;
            tally_and_finish();
        end
        q = prdata;
        err = pslverr;
        penable <= 1'h0;
    endtask
    task automatic op(input logic [1:0] kind, input logic bm);
        int n;
        apb(1'h1, PTA_ADDR_PAGE, {24'h0, pg});
        apb(1'h1, PTA_ADDR_EA, {16'h0, ea});
        apb(1'h1, PTA_ADDR_WDATA, {16'h0, ~ea});
        seen_lane <= 3'h7;
        apb(1'h1, PTA_ADDR_CTRL, {23'h0, 1'h1, 5'h0, bm, kind});
        n = 0;
        do begin
            apb(1'h0, PTA_ADDR_STATUS, 32'h0);
            n++;
        end while (q[PTA_STAT_BUSY_BIT] !== 1'h0 && n < 10);
        if (q[PTA_STAT_BUSY_BIT] !== 1'h0) begin
            miscompares++;
            tally_and_finish();
        end
        check("space flag", {31'h0, pg[7]}, {31'h0, q[PTA_STAT_CFG_BIT]});
        check("done flag", 32'h1, {31'h0, q[PTA_STAT_DONE_BIT]});
        apb(1'h0, PTA_ADDR_RDATA, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, PTA_ADDR_PAGE, 32'h0);
        check("page reset", 32'h0, q);
        apb(1'h0, 12'h018, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        $display("reset and map test done");
        for (int i = 0; i < 16; i++) begin
            pg = {i[0] ^ i[2], 3'h5, i[3:0]};
            ea = {4'hA, i[3:1], 8'h3C, i[2]};
            a = {pg, ea[15:1]};
            w = {a[7:0] ^ pg, a[15:0] ^ 16'hC396};
            op({i[3], i[0]}, i[1]);
            if (!i[3]) begin
                if (!i[0])
                    e = i[1] ? {8'h0, i[2] ? w[15:8] : w[7:0]} : w[15:0];
                else
                    e = (i[1] && i[2]) ? 16'h0000 : {8'h0, w[23:16]};
                check("read data", {16'h0, e}, q);
            end else begin
                el = i[0] ? ((i[1] && i[2]) ? 3'h0 : 3'h4) : (!i[1] ? 3'h3 : 3'h1 << i[2]);
                m = {{8{el[2]}}, {8{el[1]}}, {8{el[0]}}};
                e = ~ea;
                x = m & {e[7:0], i[1] ? e[7:0] : e[15:8], e[7:0]};
                check("write lanes", {29'h0, el}, {29'h0, seen_lane});
                check("write data", {8'h0, x}, {8'h0, m & seen_data});
            end
        end
        $display("table op test done");
        apb(1'h1, PTA_ADDR_CTRL, 32'h0000_0100);
        apb(1'h1, PTA_ADDR_PAGE, 32'h0000_0011);
        apb(1'h0, PTA_ADDR_PAGE, 32'h0);
        check("page while busy", {24'h0, pg}, q);
        psel <= 1'h0;
        $display("refusal test done");
        tally_and_finish();
    end
endmodule // tb_top
bind pta_table_access pta_checker pta_checker_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prog_word_addr, .prog_cfg_space, .prog_rd_en,
    .buf_wr_en, .buf_wr_lane);
